// File: hdl/unvm_reader.v
// User nonvolatile memory: core byte read port and scan-side and tap-side bank programming
`timescale 1ns/100ps
`include "unvm_regs.vh"

module unvm_reader (
  input wire clk_i,
  input wire reset_i,
  // Core fabric read port
  input wire rd_en_i,
  input wire [`UNVM_ADDR_W-1:0] rd_addr_i,
  output reg [7:0] rd_data_o,
  // Core fabric programming attempt, always refused
  input wire core_prog_i,
  output reg core_refused_o,
  // Boundary-scan port bank access
  input wire scan_prog_i,
  input wire scan_read_i,
  input wire [`UNVM_BANK_W-1:0] scan_bank_i,
  input wire [`UNVM_BANK_BITS-1:0] scan_wdata_i,
  // Core-side test tap bank access
  input wire tap_prog_i,
  input wire tap_read_i,
  input wire [`UNVM_BANK_W-1:0] tap_bank_i,
  input wire [`UNVM_BANK_BITS-1:0] tap_wdata_i,
  // Shared answers for both bank access ports
  output reg [`UNVM_BANK_BITS-1:0] bank_rdata_o,
  output reg bank_rvalid_o,
  output reg answer_tap_o,
  output reg prog_done_o,
  output reg busy_o
);

  // Sequencer: IDLE waits for a bank program request; ERASE wipes the chosen
  // bank on its first cycle and then waits out the erase time; WRITE waits
  // out the write time and commits the new contents on its last cycle.
  // Core reads of the bank being programmed see all ones from the erase edge until the
  // commit, so software must not read a bank while it is being replaced.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ERASE = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  // Phase lengths in clock cycles
  localparam [7:0] ERASE_CNT = `UNVM_ERASE_CYCLES;
  localparam [7:0] WRITE_CNT = `UNVM_WRITE_CYCLES;

  // Sequencer state and phase counter
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] cnt;
  reg [7:0] next_cnt;
  reg next_busy;
  // Bank operation held for the whole erase and write
  reg [`UNVM_BANK_W-1:0] op_bank;
  reg [`UNVM_BANK_BITS-1:0] op_data;
  // Array connections
  wire [7:0] arr_byte;
  wire [`UNVM_BANK_BITS-1:0] arr_bank;
  wire [`UNVM_BANK_W-1:0] pick_bank;
  wire arr_erase;
  wire arr_write;
  // Request decode
  wire idle;
  wire scan_req;
  wire tap_req;
  wire any_req;
  wire take_prog;
  wire take_read;

  // Boundary scan wins when both ports ask in the same cycle
  assign idle = (state == ST_IDLE);
  assign scan_req = scan_prog_i | scan_read_i;
  assign tap_req = tap_prog_i | tap_read_i;
  assign any_req = idle & (scan_req | tap_req);
  assign pick_bank = scan_req ? scan_bank_i : tap_bank_i;
  // Program beats read within one port, so a stray read level never
  // turns a program into a readback
  assign take_prog = any_req & (scan_req ? scan_prog_i : tap_prog_i);
  assign take_read = any_req & ~take_prog;

  // Erase fires once on entry to the erase phase; write commits at its end
  assign arr_erase = (state == ST_ERASE) && (cnt == 8'h00);
  assign arr_write = (state == ST_WRITE) && (cnt == WRITE_CNT - 8'h01);

  // Array has no write path from the core read port at all
  unvm_array u_array (
    .clk_i(clk_i),
    .erase_i(arr_erase),
    .write_i(arr_write),
    .wr_bank_i(op_bank),
    .wr_data_i(op_data),
    .rd_addr_i(rd_addr_i),
    .rd_byte_o(arr_byte),
    .bank_rd_i(pick_bank),
    .bank_rd_data_o(arr_bank)
  );

  // Core read: address captured on the rising edge, byte lands on that
  // same edge, so it is stable well before the falling edge; reset clears
  // only this byte, the array keeps its contents
  always @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_o <= `UNVM_RST_BYTE;
    end else if (rd_en_i) begin
      rd_data_o <= arr_byte;
    end else begin
      rd_data_o <= rd_data_o;
    end
  end

  // Core programming attempts are answered with a refusal pulse only;
  // nothing from the core side reaches the array's write controls
  always @(posedge clk_i) begin
    if (reset_i) begin
      core_refused_o <= 1'b0;
    end else begin
      core_refused_o <= core_prog_i;
    end
  end

  // Programming sequencer next state
  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        next_cnt = `UNVM_RST_CNT;
        // Only a program leaves idle; a bank readback takes a single cycle
        if (take_prog) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        // Erase edge is count zero; the rest is erase settling time
        if (cnt == ERASE_CNT - 8'h01) begin
          next_state = ST_WRITE;
          next_cnt = `UNVM_RST_CNT;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      ST_WRITE: begin
        // Commit happens on the last count, then back to idle
        if (cnt == WRITE_CNT - 8'h01) begin
          next_state = ST_IDLE;
          next_cnt = `UNVM_RST_CNT;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      default: begin
        // Unused code: fall back to idle rather than lock up
        next_state = ST_IDLE;
        next_cnt = `UNVM_RST_CNT;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  // Sequencer registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      cnt <= `UNVM_RST_CNT;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy_o <= next_busy;
    end
  end

  // Latch the granted bank operation; requests while busy are dropped.
  // Data is copied here so the requester may change its inputs at once.
  always @(posedge clk_i) begin
    if (reset_i) begin
      op_bank <= {`UNVM_BANK_W{1'b0}};
      op_data <= {`UNVM_BANK_BITS{1'b0}};
    end else if (take_prog) begin
      op_bank <= pick_bank;
      op_data <= scan_req ? scan_wdata_i : tap_wdata_i;
    end
  end

  // Bank readback for read-modify-write by either port
  always @(posedge clk_i) begin
    if (reset_i) begin
      bank_rdata_o <= {`UNVM_BANK_BITS{1'b0}};
      bank_rvalid_o <= 1'b0;
    end else begin
      bank_rvalid_o <= take_read;
      if (take_read) begin
        bank_rdata_o <= arr_bank;
      end
    end
  end

  // Owner of the last accepted request, kept so a port can tell whose answer
  // is on the shared outputs
  always @(posedge clk_i) begin
    if (reset_i) begin
      answer_tap_o <= 1'b0;
    end else if (any_req) begin
      answer_tap_o <= !scan_req;
    end
  end

  // Commit pulse lines up with busy_o falling
  always @(posedge clk_i) begin
    if (reset_i) begin
      prog_done_o <= 1'b0;
    end else begin
      prog_done_o <= arr_write;
    end
  end

endmodule // unvm_reader

// File: shared/unvm_regs.vh
// Constants for the user nonvolatile memory byte reader
`ifndef UNVM_REGS_VH
`define UNVM_REGS_VH

// Geometry
`define UNVM_ADDR_W 7
`define UNVM_BANK_W 3
`define UNVM_BYTE_W 4
`define UNVM_BANKS 8
`define UNVM_BANK_BITS 128
`define UNVM_BANK_MSB 6
`define UNVM_BANK_LSB 4
`define UNVM_BYTE_MSB 3
`define UNVM_BYTE_LSB 0

// Value of a freshly erased bank
`define UNVM_ERASED_BANK {16{8'hff}}

// Reset values
`define UNVM_RST_BYTE 8'h00
`define UNVM_RST_CNT 8'h00

// Timing at the 50 ns clock: erase 2000 ns and write 1000 ns, in cycles
`define UNVM_ERASE_CYCLES 8'h28
`define UNVM_WRITE_CYCLES 8'h14

`endif

// File: hdl/unvm_array.v
// Storage array of the user nonvolatile memory: eight banks of 128 bits
`timescale 1ns/100ps
`include "unvm_regs.vh"

module unvm_array (
  input wire clk_i,
  input wire erase_i,
  input wire write_i,
  input wire [`UNVM_BANK_W-1:0] wr_bank_i,
  input wire [`UNVM_BANK_BITS-1:0] wr_data_i,
  input wire [`UNVM_ADDR_W-1:0] rd_addr_i,
  output wire [7:0] rd_byte_o,
  input wire [`UNVM_BANK_W-1:0] bank_rd_i,
  output wire [`UNVM_BANK_BITS-1:0] bank_rd_data_o
);

  // Contents survive reset on purpose: the store is nonvolatile
  reg [`UNVM_BANK_BITS-1:0] mem [0:`UNVM_BANKS-1];
  wire [`UNVM_BANK_BITS-1:0] sel_bank;

  // Only one bank ever changes per operation; others keep their bits
  always @(posedge clk_i) begin
    if (erase_i) begin
      mem[wr_bank_i] <= `UNVM_ERASED_BANK;
    end else if (write_i) begin
      mem[wr_bank_i] <= wr_data_i;
    end
  end

  // Byte select: upper bits pick the bank, lower bits the byte
  assign sel_bank = mem[rd_addr_i[`UNVM_BANK_MSB:`UNVM_BANK_LSB]];
  assign rd_byte_o = sel_bank[{rd_addr_i[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB], 3'h0} +: 8];
  assign bank_rd_data_o = mem[bank_rd_i];

endmodule // unvm_array

// File: test/unvm_reader_monitor.sv
// Port assertions for the user nonvolatile memory byte reader
`timescale 1ns/100ps
module unvm_reader_monitor (
  input wire clk_i,
  input wire reset_i,
  input wire rd_en_i,
  input wire [7:0] rd_data_o,
  input wire core_prog_i,
  input wire core_refused_o,
  input wire scan_prog_i,
  input wire scan_read_i,
  input wire tap_read_i,
  input wire busy_o,
  input wire prog_done_o,
  input wire bank_rvalid_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Byte output holds while no new address is taken
  property p_hold;
    !rd_en_i |=> $stable(rd_data_o);
  endproperty
  property p_refuse;
    core_prog_i |=> core_refused_o;
  endproperty
  property p_quiet;
    !core_prog_i |=> !core_refused_o;
  endproperty
  // Idle port must take a scan program request
  property p_accept;
    scan_prog_i && !busy_o && !prog_done_o |=> busy_o;
  endproperty
  // Erase plus write span is fixed at 60 cycles
  property p_done;
    $rose(busy_o) |-> ##60 prog_done_o;
  endproperty
  property p_done_fall;
    prog_done_o |-> !busy_o && $past(busy_o);
  endproperty
  property p_read;
    scan_read_i && !scan_prog_i && !busy_o && !prog_done_o |=> bank_rvalid_o;
  endproperty
  property p_rvalid;
    bank_rvalid_o |-> $past(scan_read_i || tap_read_i);
  endproperty
  a_hold: assert property (p_hold) else $error("byte output moved");
  a_refuse: assert property (p_refuse) else $error("no refusal");
  a_quiet: assert property (p_quiet) else $error("stray refusal");
  a_accept: assert property (p_accept) else $error("program not taken");
  a_done: assert property (p_done) else $error("program span wrong");
  a_done_fall: assert property (p_done_fall) else $error("busy not ended");
  a_read: assert property (p_read) else $error("bank read lost");
  a_rvalid: assert property (p_rvalid) else $error("stray bank data");
  c_done: cover property (prog_done_o);
  c_rvalid: cover property (bank_rvalid_o);
  c_refuse: cover property (core_refused_o);
endmodule // unvm_reader_monitor

bind unvm_reader unvm_reader_monitor i_unvm_reader_monitor (.clk_i(clk_i), .reset_i(reset_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .core_prog_i(core_prog_i),
  .core_refused_o(core_refused_o), .scan_prog_i(scan_prog_i), .scan_read_i(scan_read_i),
  .tap_read_i(tap_read_i), .busy_o(busy_o), .prog_done_o(prog_done_o),
  .bank_rvalid_o(bank_rvalid_o));

// File: test/unvm_fabric_user.sv
// Core fabric user model on the byte read port
`timescale 1ns/100ps
module unvm_fabric_user (
  input wire clk_i,
  input wire [7:0] rd_data_i,
  output reg rd_en_o = 1'h0,
  output reg [6:0] rd_addr_o = 7'h00,
  output reg core_prog_o = 1'h0
);
  // One byte read; released address is inverted so stale values never match
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      #1;
      rd_en_o = 1'h1;
      rd_addr_o = a;
      @(posedge clk_i);
      #1;
      rd_en_o = 1'h0;
      rd_addr_o = ~a;
      @(negedge clk_i);
      d = rd_data_i;
    end
  endtask
  // Single-cycle write attempt from the fabric
  task poke;
    begin
      @(posedge clk_i);
      #1;
      core_prog_o = 1'h1;
      @(posedge clk_i);
      #1;
      core_prog_o = 1'h0;
    end
  endtask
endmodule // unvm_fabric_user

// File: test/tb_top.sv
// Self-checking bench for the user nonvolatile memory byte reader
`timescale 1ns/100ps
module tb_top;
  reg clk_i = 1'h0;
  reg reset_i = 1'h1;
  reg sp = 1'h0, sr = 1'h0, tp = 1'h0, tr = 1'h0;
  reg [2:0] bk = 3'h0;
  reg [127:0] wd = 128'h0;
  reg [127:0] pat = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  reg [7:0] d;
  wire rd_en, core_prog, refused, rvalid, ans_tap, done, busy;
  wire [6:0] rd_addr;
  wire [7:0] rd_data;
  wire [127:0] rdata;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer k;
  always #25 clk_i = ~clk_i;
  unvm_reader i_unvm_reader (.clk_i(clk_i), .reset_i(reset_i), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .core_prog_i(core_prog),
    .core_refused_o(refused), .scan_prog_i(sp), .scan_read_i(sr), .scan_bank_i(bk),
    .scan_wdata_i(wd), .tap_prog_i(tp), .tap_read_i(tr), .tap_bank_i(bk),
    .tap_wdata_i(wd), .bank_rdata_o(rdata), .bank_rvalid_o(rvalid),
    .answer_tap_o(ans_tap), .prog_done_o(done), .busy_o(busy));
  unvm_fabric_user i_unvm_fabric_user (.clk_i(clk_i), .rd_data_i(rd_data),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr), .core_prog_o(core_prog));
  task chk(input [127:0] seen, input [127:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Program a bank, peek that it was erased first, wait bounded for commit
  task prog(input tap, input [2:0] b, input [127:0] v);
    integer n;
    begin
      @(posedge clk_i);
      #1;
      tp = tap;
      sp = !tap;
      bk = b;
      wd = v;
      @(posedge clk_i);
      #1;
      tp = 1'h0;
      sp = 1'h0;
      wd = ~v;
      i_unvm_fabric_user.rd({b, 4'h0}, d);
      chk(d, 8'hff);
      n = 0;
      while (done !== 1'h1 && n < 100) begin
        @(posedge clk_i);
        #1;
        n = n + 1;
      end
      chk(done, 1'h1);
    end
  endtask
  // Whole-bank read through scan or tap
  task bread(input tap, input [2:0] b, input [127:0] v);
    begin
      @(posedge clk_i);
      #1;
      tr = tap;
      sr = !tap;
      bk = b;
      @(posedge clk_i);
      #1;
      tr = 1'h0;
      sr = 1'h0;
      chk(rvalid, 1'h1);
      chk(rdata, v);
      chk(ans_tap, tap);
    end
  endtask
  // Every byte of one bank, in bank order
  task t_prog;
    begin
      prog(1'h0, 3'h2, pat);
      for (k = 0; k < 16; k = k + 1) begin
        i_unvm_fabric_user.rd({3'h2, k[3:0]}, d);
        chk(d, pat[8*k +: 8]);
      end
      bread(1'h1, 3'h2, pat);
      $display("bank program test done");
    end
  endtask
  // Second bank written via tap leaves the first intact
  task t_keep;
    begin
      prog(1'h1, 3'h4, ~pat);
      i_unvm_fabric_user.rd(7'h27, d);
      chk(d, pat[63:56]);
      bread(1'h0, 3'h4, ~pat);
      $display("bank keep test done");
    end
  endtask
  // Fabric write attempt is refused and the byte output holds
  task t_refuse;
    begin
      i_unvm_fabric_user.poke;
      chk(refused, 1'h1);
      i_unvm_fabric_user.rd(7'h41, d);
      chk(d, pat[15:8] ^ 8'hff);
      repeat (3) @(posedge clk_i);
      #1;
      chk(rd_data, pat[15:8] ^ 8'hff);
      $display("refuse test done");
    end
  endtask
  // Watchdog sized well above the expected run of under two hundred cycles
  initial begin
    #(50 * 2000);
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    reset_i = 1'h0;
    t_prog;
    t_keep;
    t_refuse;
    test_done;
  end
endmodule // tb_top
